// file: include/rgar_pkg.sv
// Package for the radio pin-routing, antenna-switch and signal-strength block.
// Assumes one 100 MHz clock and an 8-bit register port with one-cycle read latency.
package rgar_pkg;
   localparam logic [7:0] OFS_OPCTL2 = 8'h08;
   localparam logic [7:0] OFS_PIN0_CFG = 8'h0B;
   localparam logic [7:0] OFS_PIN1_CFG = 8'h0C;
   localparam logic [7:0] OFS_PIN2_CFG = 8'h0D;
   localparam logic [7:0] OFS_IO_CFG = 8'h0E;
   localparam logic [7:0] OFS_STRENGTH = 8'h26;
   localparam logic [7:0] OFS_THRESHOLD = 8'h27;
   localparam logic [7:0] OFS_RADIO_STAT = 8'h04;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;
   // Bit position of the clear-channel flag in the second status register
   localparam int CCA_BIT = 4;
   // Function codes
   localparam logic [4:0] FN_DEFAULT = 5'h00;
   localparam logic [4:0] FN_DIRECT_IO = 5'h0A;
   localparam logic [4:0] FN_CCA = 5'h0E;
   localparam logic [4:0] FN_TRANSMIT_RECEIVE_SWITCH_TX = 5'h12;
   localparam logic [4:0] FN_TRANSMIT_RECEIVE_SWITCH_RX = 5'h13;
   localparam logic [4:0] FN_ANT1 = 5'h17;
   localparam logic [4:0] FN_ANT2 = 5'h18;
   localparam logic [4:0] FN_VDD = 5'h1D;
   localparam logic [4:0] FN_GND = 5'h1F;
   // Antenna-control codes
   localparam logic [2:0] AC_FIX01 = 3'h0;
   localparam logic [2:0] AC_FIX10 = 3'h1;
   localparam logic [2:0] AC_FIX01H = 3'h2;
   localparam logic [2:0] AC_FIX10H = 3'h3;
   // Toggle period of the hunting antenna switch, in nanoseconds, then in cycles
   localparam int TOGGLE_NS = 10000;
   localparam int TOGGLE_CYC = TOGGLE_NS / 10;
   localparam logic [9:0] TOGGLE_LAST = 10'(TOGGLE_CYC - 1);
   // Strength sampling window per antenna in preamble, in cycles
   localparam logic [9:0] DWELL_LAST = 10'(TOGGLE_CYC - 1);

   typedef enum logic [2:0] {
      RGAR_IDLE = 3'b000,
      RGAR_HUNT = 3'b001,
      RGAR_MEAS_A = 3'b010,
      RGAR_MEAS_B = 3'b011,
      RGAR_HOLD = 3'b100
   } rgar_div_t;

   typedef struct packed {
      logic [1:0] pinDriveStrength;
      logic pinPullupEnable;
      logic [4:0] pinFunctionSelect;
   } rgar_pincfg_t;

   typedef struct packed {
      logic shutdown;
      logic rxOn;
      logic txOn;
      logic porFlag;
      logic mcuClk;
      logic preambleDet;
      logic syncDet;
      logic strengthTick;
   } rgar_radio_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rgar_bus_t;
endpackage

// file: verilog/rgar_top.sv
// Pin routing, antenna-diversity switch control and signal-strength flag logic.
// Assumes radio status inputs synchronous to sys_clk; strength arrives as 8-bit word.
//
// Decided for this implementation: strobed register access.
module rgar_top
   import rgar_pkg::*;
(
   input wire logic sys_clk,
   input wire logic srst,
   input wire rgar_bus_t bus,
   output logic [7:0] rdData,
   input wire rgar_radio_t radio,
   input wire logic [7:0] strengthIn,
   input wire logic [2:0] pinIn,
   output logic [2:0] pinOut,
   output logic [2:0] pinOe,
   output logic [5:0] pinDrive,
   output logic [2:0] pinPullup,
   output logic antennaSwitchOut
);
   logic [7:0] opCtl2_q;
   rgar_pincfg_t pinCfg_q [3];
   logic [7:0] ioCfg_q;
   logic [7:0] threshold_q;
   logic [7:0] strength_q;
   logic ccaFlag_q;
   logic [7:0] rdData_q;
   rgar_div_t divState_q;
   logic divAnt_q;
   logic [9:0] divCnt_q;
   logic [7:0] measA_q;
   logic rxOnPrev_q;
   logic preamblePrev_q;
   logic ant1;
   logic ant2;
   logic inPacketMode;
   logic divMode;
   logic [2:0] antCode;

   // Shared register-write decode
   function automatic logic wrHit(rgar_bus_t b, logic [7:0] ofs);
      return b.wr && (b.addr == ofs);
   endfunction

   assign antCode = opCtl2_q[7:5];
   assign inPacketMode = radio.rxOn | radio.txOn;
   assign divMode = antCode[2];

   // Writable configuration; threshold resets to zero
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         opCtl2_q <= RST_ZERO;
         ioCfg_q <= RST_ZERO;
         threshold_q <= RST_ZERO;
      end else begin
         if (wrHit(bus, OFS_OPCTL2)) opCtl2_q <= bus.wdata;
         if (wrHit(bus, OFS_IO_CFG)) ioCfg_q <= bus.wdata;
         if (wrHit(bus, OFS_THRESHOLD)) threshold_q <= bus.wdata;
      end
   end

   // Per-pin configuration registers
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_cfg
         always_ff @(posedge sys_clk) begin
            if (srst) begin
               pinCfg_q[gi] <= rgar_pincfg_t'(RST_ZERO);
            end else if (wrHit(bus, OFS_PIN0_CFG + 8'(gi))) begin
               pinCfg_q[gi] <= rgar_pincfg_t'(bus.wdata);
            end
         end
      end
   endgenerate

   // Strength sampled only on the radio's update tick, once per four bit times
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         strength_q <= RST_ZERO;
      end else if (radio.strengthTick) begin
         strength_q <= strengthIn;
      end
   end

   // Clear-channel decision at preamble detection; the event beats the clear while receive is off
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ccaFlag_q <= 1'b0;
      end else if (radio.preambleDet && !preamblePrev_q) begin
         ccaFlag_q <= strength_q > threshold_q;
      end else if (!radio.rxOn) begin
         ccaFlag_q <= 1'b0;
      end
   end

   // Read port, data stands the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rdData_q <= UNMAPPED_DATA;
      end else if (bus.rd) begin
         case (bus.addr)
            OFS_OPCTL2: rdData_q <= opCtl2_q;
            OFS_PIN0_CFG: rdData_q <= pinCfg_q[0];
            OFS_PIN1_CFG: rdData_q <= pinCfg_q[1];
            OFS_PIN2_CFG: rdData_q <= pinCfg_q[2];
            OFS_IO_CFG: rdData_q <= {ioCfg_q[7:3], pinIn};
            OFS_STRENGTH: rdData_q <= strength_q;
            OFS_THRESHOLD: rdData_q <= threshold_q;
            OFS_RADIO_STAT: rdData_q <= 8'(ccaFlag_q) << CCA_BIT;
            default: rdData_q <= UNMAPPED_DATA;
         endcase
      end else begin
         rdData_q <= UNMAPPED_DATA;
      end
   end
   assign rdData = rdData_q;

   // Edge history for receive entry and preamble detection
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         rxOnPrev_q <= 1'b0;
         preamblePrev_q <= 1'b0;
      end else begin
         rxOnPrev_q <= radio.rxOn;
         preamblePrev_q <= radio.preambleDet;
      end
   end

   // Diversity engine: hunt, measure each antenna, hold the winner
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         divState_q <= RGAR_IDLE;
         divAnt_q <= 1'b0;
         divCnt_q <= '0;
         measA_q <= RST_ZERO;
      end else if (!divMode || !inPacketMode) begin
         // Antenna kept so the next transmit reuses it
         divState_q <= RGAR_IDLE;
         divCnt_q <= '0;
      end else begin
         case (divState_q)
            RGAR_IDLE: begin
               divCnt_q <= '0;
               if (radio.rxOn && !rxOnPrev_q) begin
                  // Beacon variant measures right away, packet expected at enable
                  divState_q <= antCode[1] ? RGAR_MEAS_A : RGAR_HUNT;
                  divAnt_q <= 1'b0;
               end
            end
            RGAR_HUNT: begin
               // Alternate until the packet shows up
               if (radio.preambleDet) begin
                  divState_q <= RGAR_MEAS_A;
                  divAnt_q <= 1'b0;
                  divCnt_q <= '0;
               end else if (divCnt_q == TOGGLE_LAST) begin
                  divAnt_q <= ~divAnt_q;
                  divCnt_q <= '0;
               end else begin
                  divCnt_q <= divCnt_q + 10'd1;
               end
            end
            RGAR_MEAS_A: begin
               if (divCnt_q == DWELL_LAST) begin
                  measA_q <= strength_q;
                  divAnt_q <= 1'b1;
                  divCnt_q <= '0;
                  divState_q <= RGAR_MEAS_B;
               end else begin
                  divCnt_q <= divCnt_q + 10'd1;
               end
            end
            RGAR_MEAS_B: begin
               if (divCnt_q == DWELL_LAST) begin
                  divAnt_q <= strength_q > measA_q;
                  divState_q <= RGAR_HOLD;
               end else begin
                  divCnt_q <= divCnt_q + 10'd1;
               end
            end
            RGAR_HOLD: begin
               // Stay on the winner until receive and transmit both end
               if (!radio.rxOn && !radio.txOn) divState_q <= RGAR_IDLE;
            end
            default: divState_q <= RGAR_IDLE;
         endcase
      end
   end

   // Antenna outputs from control code and radio state
   always_comb begin
      if (!inPacketMode) begin
         // Even codes low except 010, odd codes high except 001
         ant1 = (antCode == AC_FIX10) ? 1'b0 : antCode[0] | (antCode == AC_FIX01H);
      end else if (divMode) begin
         ant1 = ~divAnt_q;
      end else begin
         ant1 = (antCode == AC_FIX10) || (antCode == AC_FIX10H);
      end
      ant2 = inPacketMode ? ~ant1 : ant1;
   end

   // Dedicated antenna pin mirrors the second antenna function
   assign antennaSwitchOut = radio.shutdown ? 1'b0 : ant2;

   // Per-pin function mux, drive and pull-up
   generate
      for (gi = 0; gi < 3; gi++) begin : g_pin
         logic fnOut;
         always_comb begin
            case (pinCfg_q[gi].pinFunctionSelect)
               FN_DEFAULT: begin
                  // Pin-specific default
                  if (gi == 0) fnOut = radio.porFlag;
                  else if (gi == 1) fnOut = ~radio.porFlag;
                  else fnOut = radio.mcuClk;
               end
               FN_DIRECT_IO: fnOut = ioCfg_q[gi];
               FN_CCA: fnOut = ccaFlag_q;
               FN_TRANSMIT_RECEIVE_SWITCH_TX: fnOut = radio.txOn;
               FN_TRANSMIT_RECEIVE_SWITCH_RX: fnOut = radio.rxOn;
               FN_ANT1: fnOut = ant1;
               FN_ANT2: fnOut = ant2;
               FN_VDD: fnOut = 1'b1;
               FN_GND: fnOut = 1'b0;
               default: fnOut = 1'b0;
            endcase
         end
         // Shutdown pulls pads low, so the pin stays driven
         assign pinOut[gi] = radio.shutdown ? 1'b0 : fnOut;
         assign pinOe[gi] = 1'b1;
         assign pinDrive[2*gi+1:2*gi] = pinCfg_q[gi].pinDriveStrength;
         assign pinPullup[gi] = pinCfg_q[gi].pinPullupEnable;
         // Each routed function reaches its pad unless the radio is shut down
         pin_default_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_DEFAULT) |->
            pinOut[gi] == ((gi == 0) ? radio.porFlag : (gi == 1) ? !radio.porFlag : radio.mcuClk))
            else $error("default pin function wrong");
         pin_dio_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_DIRECT_IO) |->
            pinOut[gi] == ioCfg_q[gi])
            else $error("direct io pin wrong");
         pin_cca_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_CCA) |->
            pinOut[gi] == ccaFlag_q)
            else $error("clear channel pin wrong");
         pin_ant1_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_ANT1) |->
            pinOut[gi] == (inPacketMode ? !antennaSwitchOut : antennaSwitchOut))
            else $error("first antenna pin wrong");
         pin_ant2_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_ANT2) |->
            pinOut[gi] == antennaSwitchOut)
            else $error("second antenna pin differs from dedicated pin");
         pin_tx_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_TRANSMIT_RECEIVE_SWITCH_TX) |->
            pinOut[gi] == radio.txOn)
            else $error("transmit switch pin wrong");
         pin_rx_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_TRANSMIT_RECEIVE_SWITCH_RX) |->
            pinOut[gi] == radio.rxOn)
            else $error("receive switch pin wrong");
         pin_vdd_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_VDD) |->
            pinOut[gi])
            else $error("high pin function wrong");
         pin_gnd_a: assert property (@(posedge sys_clk) disable iff (srst)
            (!radio.shutdown && pinCfg_q[gi].pinFunctionSelect == FN_GND) |->
            !pinOut[gi])
            else $error("low pin function wrong");
      end
   endgenerate

   // Assertions
   shutdown_low_a: assert property (@(posedge sys_clk) disable iff (srst)
      radio.shutdown |-> (pinOut == 3'b000))
      else $error("pins not low in shutdown");
   dedicated_mirror_a: assert property (@(posedge sys_clk) disable iff (srst)
      !radio.shutdown |-> antennaSwitchOut == ant2)
      else $error("antenna pin differs from second output");
   fixed_levels_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!radio.shutdown && antCode == AC_FIX01 && inPacketMode) |-> antennaSwitchOut)
      else $error("code 000 level wrong");
   idle_even_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!radio.shutdown && divMode && !inPacketMode) |-> antennaSwitchOut == antCode[0])
      else $error("idle diversity level wrong");
   code011_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      (antCode == AC_FIX10H && !inPacketMode) |-> (ant1 && ant2))
      else $error("code 011 idle not high");
   cca_set_a: assert property (@(posedge sys_clk) disable iff (srst)
      (radio.preambleDet && !preamblePrev_q && strength_q > threshold_q) |=> ccaFlag_q)
      else $error("clear channel flag not set");
   thresh_reset_a: assert property (@(posedge sys_clk)
      srst |=> threshold_q == RST_ZERO)
      else $error("threshold reset wrong");
   strength_hold_a: assert property (@(posedge sys_clk) disable iff (srst)
      !radio.strengthTick |=> $stable(strength_q))
      else $error("strength changed off tick");
   hold_stable_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_HOLD && $past(divState_q) == RGAR_HOLD) |-> $stable(divAnt_q))
      else $error("antenna changed while held");
   hunt_toggle_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_HUNT && divCnt_q == TOGGLE_LAST && !radio.preambleDet && divMode
       && inPacketMode) |=> divAnt_q != $past(divAnt_q))
      else $error("hunt did not toggle");

   // Fixed levels, register port and the diversity sequence step by step
   fixed_rx_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!radio.shutdown && !divMode && inPacketMode) |-> antennaSwitchOut == !antCode[0])
      else $error("fixed receive level wrong");
   strength_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      (bus.rd && bus.addr == OFS_STRENGTH) |=> rdData == $past(strength_q))
      else $error("strength read wrong");
   thresh_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      (bus.rd && bus.addr == OFS_THRESHOLD) |=> rdData == $past(threshold_q))
      else $error("threshold read wrong");
   thresh_write_a: assert property (@(posedge sys_clk) disable iff (srst)
      wrHit(bus, OFS_THRESHOLD) |=> threshold_q == $past(bus.wdata))
      else $error("threshold write lost");
   stat_read_a: assert property (@(posedge sys_clk) disable iff (srst)
      (bus.rd && bus.addr == OFS_RADIO_STAT) |=> rdData[CCA_BIT] == $past(ccaFlag_q))
      else $error("status read wrong");
   cca_clear_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!radio.rxOn && !(radio.preambleDet && !preamblePrev_q)) |=> !ccaFlag_q)
      else $error("clear channel flag not cleared");
   idle_leave_a: assert property (@(posedge sys_clk) disable iff (srst)
      (!divMode || !inPacketMode) |=> divState_q == RGAR_IDLE)
      else $error("diversity not idle outside packets");
   hunt_start_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_IDLE && divMode && radio.rxOn && !rxOnPrev_q && !antCode[1]) |=>
      divState_q == RGAR_HUNT)
      else $error("hunt not started");
   beacon_start_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_IDLE && divMode && radio.rxOn && !rxOnPrev_q && antCode[1]) |=>
      divState_q == RGAR_MEAS_A)
      else $error("beacon measure not started");
   hunt_exit_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_HUNT && radio.preambleDet && divMode && inPacketMode) |=>
      (divState_q == RGAR_MEAS_A && !divAnt_q))
      else $error("preamble did not start measuring");
   meas_swap_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_MEAS_A && divCnt_q == DWELL_LAST && divMode && inPacketMode) |=>
      (divState_q == RGAR_MEAS_B && divAnt_q))
      else $error("second antenna not measured");
   meas_pick_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_MEAS_B && divCnt_q == DWELL_LAST && divMode && inPacketMode) |=>
      divAnt_q == ($past(strength_q) > $past(measA_q)))
      else $error("stronger antenna not chosen");
   tx_keep_a: assert property (@(posedge sys_clk) disable iff (srst)
      (divState_q == RGAR_HOLD && radio.txOn) |=> $stable(divAnt_q))
      else $error("transmit antenna changed");

   hunt_c: cover property (@(posedge sys_clk) divState_q == RGAR_HUNT);
   hold_c: cover property (@(posedge sys_clk) divState_q == RGAR_HOLD && divAnt_q);
   cca_c: cover property (@(posedge sys_clk) ccaFlag_q);
   beacon_c: cover property (@(posedge sys_clk) divState_q == RGAR_MEAS_A && antCode[1]);
   reuse_c: cover property (@(posedge sys_clk) divState_q == RGAR_HOLD && radio.txOn);
endmodule // rgar_top

// file: test/rgar_rf_env.sv
// Far-side model: antenna switch and front end feeding strength words.
// Assumes the antenna pin high selects the second antenna.
module rgar_rf_env #(
   parameter int TICK_CYC = 40
) (
   input wire logic sys_clk,
   input wire logic antSel,
   input wire logic strongHigh,
   output logic strengthTick,
   output logic [7:0] strengthIn
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   // Known levels from time zero so the first samples are not unknown
   initial begin
      strengthTick = 1'b0;
      strengthIn = 8'h00;
   end
   // One update pulse every four bit times; the level follows the antenna in use
   always @(posedge sys_clk) begin
      cnt <= (cnt == TICK_CYC - 1) ? 0 : cnt + 1;
      strengthTick <= (cnt == 0);
      strengthIn <= (antSel == strongHigh) ? 8'h80 : 8'h30;
   end
endmodule // rgar_rf_env

// file: test/rgar_top_tb.sv
// Self-checking bench for the pin-routing, antenna and signal-strength block.
// Assumes rgar_pkg and the far-side model are compiled first.
module rgar_top_tb import rgar_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   rgar_bus_t bus = '0;
   rgar_radio_t ctl = '0;
   rgar_radio_t radio;
   logic [7:0] rdData, strengthIn, rv;
   logic [2:0] pinOut, pinOe, pinPullup;
   logic [5:0] pinDrive;
   logic antennaSwitchOut, tick;
   logic strongHigh = 1'b1;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;

   always #5 sys_clk = ~sys_clk;
   // The update pulse comes from the far-side model, the rest from the bench
   always_comb begin
      radio = ctl;
      radio.strengthTick = tick;
   end

   rgar_top u_rgar_top (.sys_clk(sys_clk), .srst(srst), .bus(bus), .rdData(rdData),
      .radio(radio), .strengthIn(strengthIn), .pinIn(3'h0), .pinOut(pinOut), .pinOe(pinOe),
      .pinDrive(pinDrive), .pinPullup(pinPullup), .antennaSwitchOut(antennaSwitchOut));
   rgar_rf_env u_rgar_rf_env (.sys_clk(sys_clk), .antSel(antennaSwitchOut),
      .strongHigh(strongHigh), .strengthTick(tick), .strengthIn(strengthIn));

   task automatic final_report();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 d = rdData;
   endtask

   task automatic t_regs();
      logic [7:0] ofs [7] = '{OFS_OPCTL2, OFS_PIN0_CFG, OFS_PIN1_CFG, OFS_PIN2_CFG,
                              OFS_IO_CFG, OFS_THRESHOLD, 8'h40};
      foreach (ofs[i]) begin
         rd(ofs[i], rv);
         chk("reset value", RST_ZERO, rv);
      end
      wr(OFS_THRESHOLD, 8'hA5);
      rd(OFS_THRESHOLD, rv);
      chk("threshold", 8'hA5, rv);
   endtask

   task automatic t_pins();
      ctl.porFlag <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("default pins", 8'h01, {5'h0, pinOut});
      ctl.porFlag <= 1'b0;
      ctl.mcuClk <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("default pins", 8'h06, {5'h0, pinOut});
      chk("pin enables", 8'h07, {5'h0, pinOe});
      wr(OFS_PIN0_CFG, {2'b11, 1'b1, FN_VDD});
      wr(OFS_PIN1_CFG, {2'b01, 1'b0, FN_GND});
      wr(OFS_PIN2_CFG, {2'b10, 1'b0, FN_VDD});
      @(posedge sys_clk);
      chk("routed pins", 8'h05, {5'h0, pinOut});
      chk("drive", 8'h27, {2'h0, pinDrive});
      chk("pullup", 8'h01, {5'h0, pinPullup});
      ctl.shutdown <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("shutdown pins", 8'h00, {4'h0, antennaSwitchOut, pinOut});
      ctl.shutdown <= 1'b0;
      wr(OFS_IO_CFG, 8'h01);
      wr(OFS_PIN0_CFG, {3'b000, FN_DIRECT_IO});
      wr(OFS_PIN1_CFG, {3'b000, FN_TRANSMIT_RECEIVE_SWITCH_TX});
      wr(OFS_PIN2_CFG, {3'b000, FN_TRANSMIT_RECEIVE_SWITCH_RX});
      ctl.txOn <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk("function pins", 8'h03, {5'h0, pinOut});
      ctl.txOn <= 1'b0;
   endtask

   task automatic t_fixed();
      logic [2:0] c;
      logic [1:0] e;
      wr(OFS_PIN0_CFG, {3'b000, FN_ANT1});
      wr(OFS_PIN1_CFG, {3'b000, FN_ANT2});
      wr(OFS_PIN2_CFG, {3'b000, FN_ANT2});
      for (int k = 0; k < 12; k++) begin
         c = 3'(k / 2);
         if (c > 3'd5 || (c > 3'd3 && k[0])) continue;
         wr(OFS_OPCTL2, {c, 5'h00});
         ctl.rxOn <= k[0];
         repeat (2) @(posedge sys_clk);
         e = k[0] ? (c[0] ? 2'b10 : 2'b01) : (c[2] ? {2{c[0]}} : {2{c[1]}});
         chk("antenna pair", {6'h0, e}, {6'h0, pinOut[0], pinOut[1]});
         chk("antenna pin", {6'h0, pinOut[1], pinOut[2]}, {6'h0, {2{antennaSwitchOut}}});
      end
      ctl.rxOn <= 1'b0;
   endtask

   task automatic t_div();
      logic [2:0] c;
      int n;
      for (int k = 0; k < 4; k++) begin
         c = k[1] ? 3'b110 : 3'b100;
         wr(OFS_OPCTL2, {c, 5'h00});
         strongHigh <= k[0];
         ctl.rxOn <= 1'b1;
         if (!k[1]) begin
            n = 0;
            rv[0] = antennaSwitchOut;
            repeat (2200) begin
               @(posedge sys_clk);
               if (antennaSwitchOut !== rv[0]) n++;
               rv[0] = antennaSwitchOut;
            end
            chk("hunt toggles", 8'h01, {7'h0, n >= 2});
            ctl.preambleDet <= 1'b1;
         end
         repeat (2600) @(posedge sys_clk);
         chk("chosen antenna", {7'h0, k[0]}, {7'h0, antennaSwitchOut});
         repeat (1500) @(posedge sys_clk);
         chk("antenna held", {7'h0, k[0]}, {7'h0, antennaSwitchOut});
         ctl.rxOn <= 1'b0;
         ctl.txOn <= 1'b1;
         ctl.preambleDet <= 1'b0;
         repeat (5) @(posedge sys_clk);
         chk("transmit antenna", {6'h0, ~k[0], k[0]}, {6'h0, pinOut[0], pinOut[1]});
         ctl.txOn <= 1'b0;
      end
   endtask

   task automatic t_cca();
      wr(OFS_OPCTL2, 8'h00);
      wr(OFS_PIN2_CFG, {3'b000, FN_CCA});
      strongHigh <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         wr(OFS_THRESHOLD, k[0] ? 8'h80 : 8'h7F);
         ctl.rxOn <= 1'b1;
         repeat (100) @(posedge sys_clk);
         rd(OFS_STRENGTH, rv);
         chk("strength", 8'h80, rv);
         ctl.preambleDet <= 1'b1;
         repeat (5) @(posedge sys_clk);
         rd(OFS_RADIO_STAT, rv);
         chk("clear channel flag", {7'h0, ~k[0]}, {7'h0, rv[CCA_BIT]});
         chk("clear channel pin", {7'h0, ~k[0]}, {7'h0, pinOut[2]});
         ctl.preambleDet <= 1'b0;
         ctl.rxOn <= 1'b0;
         repeat (5) @(posedge sys_clk);
         rd(OFS_RADIO_STAT, rv);
         chk("flag after receive", 8'h00, rv);
      end
   endtask

   // Cuts a hang short well beyond the expected run length
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fail_count++;
         final_report();
      end
   end

   initial begin
      repeat (8) @(posedge sys_clk);
      srst <= 1'b0;
      t_regs();
      t_pins();
      t_fixed();
      t_div();
      t_cca();
      final_report();
   end
endmodule // rgar_top_tb
